// *** bench/tb_top.sv ***
// Purpose : Self-checking bench for the five-channel capture/compare timer
// Assumes : Register port with one-cycle strobes, read data in the following cycle
// Notes   : External count clock is tied low; checks go through chk and rng, flag poll timeouts through wait_bit
`timescale 1ns/100ps
module tb_top
  import mcct_pkg::*;
;
  logic                    ref_clk;
  logic                    rstn;
  mcct_bus_t               bus;
  logic [15:0]             rd_data;
  logic                    ext_clk_in;
  logic [NCH-1:0][NGR-1:0] pin_in;
  logic [NCH-1:0][NGR-1:0] pin_out;
  logic [NCH-1:0][NGR-1:0] pin_oe_n;
  logic [NCH-1:0]          irq_req;
  int                      err_total;
  int                      checks;
  logic [15:0]             v;
  logic [15:0]             w;

  ////////////////////////////////////////////////////////////////////////////
  // Design under test
  mcct_timer dut (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .bus       (bus),
    .rd_data   (rd_data),
    .ext_clk_in(ext_clk_in),
    .pin_in    (pin_in),
    .pin_out   (pin_out),
    .pin_oe_n  (pin_oe_n),
    .irq_req   (irq_req)
  );

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic close_out();
    $display("mismatches %0d of %0d checks", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Exact compare
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Range compare
  task automatic rng(input string n, input logic [15:0] lo, input logic [15:0] hi,
                     input logic [15:0] g);
    checks++;
    if (!(g >= lo && g <= hi)) begin
      err_total++;
      $display("[ERR] %s expected %h..%h seen %h", n, lo, hi, g);
    end
  endtask

  // Register address of a channel register
  function automatic logic [7:0] ra(input logic [3:0] ch, input logic [3:0] i);
    return {ch, i};
  endfunction

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    // Let the write settle before any direct look at outputs
    #2;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #2 d = rd_data;
  endtask

  // Poll a flag bit with a bounded count
  task automatic wait_bit(input logic [3:0] ch, input int b);
    logic [15:0] f;
    for (int i = 0; i < 200; i++) begin
      rd(ra(ch, IDX_FLAG), f);
      if (f[b] === 1'b1) return;
    end
    err_total++;
    $display("[ERR] flag wait ch %0d bit %0d expected 1 seen 0", ch, b);
    close_out();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rstn = 1'b0;
    bus = '0;
    ext_clk_in = 1'b0;
    pin_in = '0;
    err_total = 0;
    checks = 0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    // Reset values, stopped counter holds, unmapped place
    rd(ra(0, IDX_CNT), v); chk("cnt0 reset", CNT_ZERO, v);
    rd(ra(0, IDX_GRA), v); chk("gra0 reset", 16'hFFFF, v);
    rd(ra(0, IDX_CNT), v); chk("cnt0 held", CNT_ZERO, v);
    wr(8'h9F, 16'h1234);
    rd(8'h9F, v); chk("unmapped", RD_ZERO, v);
    // Free-running overflow with interrupt, masked and cleared
    wr(ra(0, IDX_CNT), 16'hFFF0);
    wr(ra(0, IDX_IER), 16'h0010);
    wr({GLB_CH, IDX_START}, 16'h0001);
    wait_bit(0, FLAG_OVF_BIT);
    chk("irq0 on", 16'h0001, {15'h0000, irq_req[0]});
    rd(ra(0, IDX_CNT), v); rng("cnt0 wrapped", 16'h0001, 16'h0100, v);
    wr(ra(0, IDX_IER), 16'h0000);
    chk("irq0 masked", 16'h0000, {15'h0000, irq_req[0]});
    wr(ra(0, IDX_FLAG), 16'h0010);
    rd(ra(0, IDX_FLAG), v); chk("ovf cleared", 16'h0000, {11'h000, v[4], 4'h0});
    // Periodic count on match A, high output
    wr(ra(1, IDX_CTRL), 16'h0001);
    wr(ra(1, IDX_GRA), 16'h0008);
    wr(ra(1, IDX_IOCTL), 16'h0002);
    wr(ra(1, IDX_IER), 16'h0001);
    wr({GLB_CH, IDX_START}, 16'h0003);
    wait_bit(1, 0);
    chk("irq1 match", 16'h0001, {15'h0000, irq_req[1]});
    chk("pin1a high", 16'h0001, {14'h0000, pin_oe_n[1][0], pin_out[1][0]});
    rd(ra(1, IDX_CNT), v); rng("cnt1 period", 16'h0000, 16'h0008, v);
    // Low on A keeps a low pin, toggle on B
    wr(ra(2, IDX_GRA), 16'h0020);
    wr(ra(2, 4'h6), 16'h0040);
    wr(ra(2, IDX_IOCTL), 16'h0831);
    wr({GLB_CH, IDX_START}, 16'h0007);
    wait_bit(2, 1);
    chk("pins2 ab", 16'h0001, {12'h000, pin_oe_n[2][0], pin_out[2][0],
        pin_oe_n[2][1], pin_out[2][1]});
    rd(ra(2, IDX_FLAG), v); chk("flags2 ab", 16'h0003, {14'h0000, v[1:0]});
    // Rising-edge capture on C, falling edge ignored
    @(posedge ref_clk);
    pin_in[2][2] <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(ra(2, 4'h7), v);
    rd(ra(2, IDX_CNT), w);
    rng("capture age", 16'h0001, 16'h0028, w - v);
    wait_bit(2, 2);
    @(posedge ref_clk);
    pin_in[2][2] <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd(ra(2, 4'h7), w); chk("no fall capture", v, w);
    // Buffered compare: C copied into A on match
    wr(ra(3, IDX_CTRL), 16'h0041);
    wr(ra(3, IDX_IOCTL), 16'h0002);
    wr(ra(3, IDX_GRA), 16'h0010);
    wr(ra(3, 4'h7), 16'h0030);
    wr({GLB_CH, IDX_START}, 16'h000F);
    wait_bit(3, 0);
    rd(ra(3, IDX_GRA), v); chk("gra3 buffered", 16'h0030, v);
    chk("pin3a high", 16'h0001, {15'h0000, pin_out[3][0]});
    // Synchronous preset of stopped channels 3 and 4
    wr({GLB_CH, IDX_START}, 16'h0000);
    wr({GLB_CH, IDX_SYNC}, 16'h0018);
    wr(ra(4, IDX_CNT), 16'h1234);
    rd(ra(3, IDX_CNT), v); chk("cnt3 preset", 16'h1234, v);
    rd(ra(4, IDX_CNT), v); chk("cnt4 held", 16'h1234, v);
    // Synchronous clear: channel 3 match clears channel 4 as well
    wr(ra(4, IDX_CTRL), 16'h0003);
    wr(ra(4, IDX_CNT), 16'h0000);
    wr(ra(3, IDX_FLAG), 16'h001F);
    wr({GLB_CH, IDX_START}, 16'h0018);
    wait_bit(3, 0);
    rd(ra(4, IDX_CNT), v); rng("cnt4 sync clear", 16'h0000, 16'h0010, v);
    // Buffered capture on both edges, counter cleared by capture A
    wr(ra(0, IDX_CTRL), 16'h0041);
    wr(ra(0, IDX_IOCTL), 16'h000A);
    wr({GLB_CH, IDX_START}, 16'h0001);
    repeat (3) begin
      @(posedge ref_clk);
      pin_in[0][0] <= ~pin_in[0][0];
      repeat (8) @(posedge ref_clk);
    end
    rd(ra(0, IDX_GRA), v); chk("gra0 both edges", 16'h0008, v);
    rd(ra(0, 4'h7), v); chk("grc0 buffered", 16'h0008, v);
    close_out();
  end
endmodule

// *** hdl/mcct_pkg.sv ***
// Purpose : Constants, types and bus carrier for the capture/compare timer
// Assumes : Register index bus, 16-bit data, 5 channels of 4 general registers
// Notes   : Addresses are word indices; addr[7:4] picks channel, addr[3:0] register
package mcct_pkg;
  localparam int         NCH          = 5;
  localparam int         NGR          = 4;
  localparam int         IO_W         = 4;
  // Address map
  localparam logic [3:0] IDX_CTRL     = 4'h0;
  localparam logic [3:0] IDX_IOCTL    = 4'h1;
  localparam logic [3:0] IDX_IER      = 4'h2;
  localparam logic [3:0] IDX_FLAG     = 4'h3;
  localparam logic [3:0] IDX_CNT      = 4'h4;
  localparam logic [3:0] IDX_GRA      = 4'h5;
  localparam logic [3:0] GLB_CH       = 4'h5;
  localparam logic [3:0] IDX_START    = 4'h0;
  localparam logic [3:0] IDX_SYNC     = 4'h1;
  // Control register fields
  localparam int         CTRL_CLR_LSB = 0;
  localparam int         CTRL_CKS_LSB = 3;
  localparam int         CTRL_BUF_LSB = 6;
  localparam logic [4:0] BUF_CH_MASK  = 5'h19;
  // Per-register I/O field and overflow flag bit
  localparam int         IO_CAP_BIT   = 3;
  localparam int         FLAG_OVF_BIT = 4;
  // Reset values and counter limits
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO    = 16'h0000;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [15:0] IO_RST      = 16'h0000;
  localparam logic [15:0] RD_ZERO     = 16'h0000;
  // Prescaler
  localparam logic [5:0] PRE_MASK_4   = 6'h03;
  localparam logic [5:0] PRE_MASK_16  = 6'h0F;
  localparam logic [5:0] PRE_MASK_64  = 6'h3F;
  localparam logic [5:0] PRE_ONE      = 6'h01;

  typedef enum logic [2:0] {CLR_NONE, CLR_A, CLR_B, CLR_SYNC, CLR_C, CLR_D} mcct_clr_t;
  typedef enum logic [2:0] {CK_DIV1, CK_DIV4, CK_DIV16, CK_DIV64, CK_EXT} mcct_cks_t;
  typedef enum logic [1:0] {OUT_NONE, OUT_LOW, OUT_HIGH, OUT_TOGGLE} mcct_out_t;
  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_ALT} mcct_edge_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } mcct_bus_t;
endpackage

// *** hdl/mcct_timer.sv ***
// Purpose : Five-channel 16-bit capture/compare timer core
// Assumes : One 40 MHz clock ref_clk, asynchronous active-low reset rstn
// Notes   : Pins and external clock are synchronised by two flip-flops
//
// Summary of operation
// - Counters count up: free-running, synchronous, or on external events.
// - Each general register works as capture or compare per its I/O field.
// - Setting a channel run bit starts its counter.
// - After reset every counter is free-running with no clear source.
// - Wrap from FFFF to 0000 sets the channel overflow flag.
// - Overflow flag with its enable set raises the channel interrupt.
// - After overflow the counter keeps counting from zero.
// - Selected compare match sets the match flag and clears the counter.
// - Match flag with its enable set raises the channel interrupt.
// - Compare match drives the pin low, high, or toggles it.
// - A match selecting the pin's present level leaves it unchanged.
// - A selected pin edge copies the counter into the capture register.
// - Capture edge is rising, falling or both, per register.
// - Channels 0 and 1 may capture on another channel's clock or match.
// - Counter can also be cleared by a selected input capture.
// - Writing one synchronous counter loads all synchronous counters.
// - Synchronous clearing clears the group when one member clears itself.
// - All five channels may join synchronous operation.
// - Buffering exists on channels 0, 3, 4: C buffers A, D buffers B.
// - Buffered compare match copies buffer to general register each match.
// - Buffered capture moves the old general value into the buffer.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/100ps
module mcct_timer
  import mcct_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire mcct_bus_t              bus,
  output logic      [15:0]            rd_data,
  input  wire logic                   ext_clk_in,
  input  wire logic [NCH-1:0][NGR-1:0] pin_in,
  output logic      [NCH-1:0][NGR-1:0] pin_out,
  output logic      [NCH-1:0][NGR-1:0] pin_oe_n,
  output logic      [NCH-1:0]         irq_req
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [15:0]            cnt_reg   [NCH];
  logic [15:0]            gr_reg    [NCH][NGR];
  logic [7:0]             ctrl_reg  [NCH];
  logic [15:0]            io_reg    [NCH];
  logic [4:0]             ier_reg   [NCH];
  logic [4:0]             flag_reg  [NCH];
  logic [NCH-1:0]         start_reg;
  logic [NCH-1:0]         sync_reg;
  logic [5:0]             pre_reg;
  logic [15:0]            rd_reg;
  logic [NCH-1:0][NGR-1:0] pin_s1_reg;
  logic [NCH-1:0][NGR-1:0] pin_s2_reg;
  logic [NCH-1:0][NGR-1:0] pin_s3_reg;
  logic [NCH-1:0][NGR-1:0] out_reg;
  logic [2:0]             ext_sync_reg;

  // Per-cycle events
  logic [NCH-1:0]         clk_src;
  logic [NCH-1:0]         tick;
  logic [NCH-1:0][NGR-1:0] cmp_hit;
  logic [NCH-1:0][NGR-1:0] cap_hit;
  logic [NCH-1:0][NGR-1:0] unit_on;
  logic [NCH-1:0][NGR-1:0] drive_on;
  logic [NCH-1:0]         own_clr;
  logic [NCH-1:0]         clr;
  logic [NCH-1:0]         ovf;
  logic [NCH-1:0]         cnt_wr;
  logic                   sync_clr_any;
  logic                   ext_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions
  function automatic logic wr_hit(input mcct_bus_t b, input logic [3:0] ch,
                                  input logic [3:0] idx);
    wr_hit = b.wr && (b.addr[7:4] == ch) && (b.addr[3:0] == idx);
  endfunction

  function automatic logic src_tick(input logic [2:0] cks, input logic [5:0] pre,
                                    input logic ext);
    case (mcct_cks_t'(cks))
      CK_DIV1:  src_tick = 1'b1;
      CK_DIV4:  src_tick = ((pre & PRE_MASK_4) == PRE_MASK_4);
      CK_DIV16: src_tick = ((pre & PRE_MASK_16) == PRE_MASK_16);
      CK_DIV64: src_tick = ((pre & PRE_MASK_64) == PRE_MASK_64);
      CK_EXT:   src_tick = ext;
      default:  src_tick = 1'b0;
    endcase
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                    input logic cur, input logic alt);
    case (mcct_edge_t'(sel))
      EDGE_RISE: edge_hit = cur && !prev;
      EDGE_FALL: edge_hit = !cur && prev;
      EDGE_BOTH: edge_hit = cur ^ prev;
      EDGE_ALT:  edge_hit = alt;
      default:   edge_hit = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and prescaler
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_reg   <= '0;
      pin_s2_reg   <= '0;
      pin_s3_reg   <= '0;
      ext_sync_reg <= '0;
      pre_reg      <= '0;
    end else begin
      pin_s1_reg   <= pin_in;
      pin_s2_reg   <= pin_s1_reg;
      pin_s3_reg   <= pin_s2_reg;
      ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_in};
      pre_reg      <= pre_reg + PRE_ONE;
    end
  end

  assign ext_rise = ext_sync_reg[1] && !ext_sync_reg[2];

  ////////////////////////////////////////////////////////////////////////////
  // Event decode: ticks, matches, captures, clears
  always_comb begin
    clk_src      = '0;
    tick         = '0;
    cmp_hit      = '0;
    cap_hit      = '0;
    unit_on      = '0;
    drive_on     = '0;
    own_clr      = '0;
    clr          = '0;
    ovf          = '0;
    cnt_wr       = '0;
    for (int ch = 0; ch < NCH; ch++) begin
      clk_src[ch] = src_tick(ctrl_reg[ch][CTRL_CKS_LSB +: 3], pre_reg, ext_rise);
      tick[ch]    = start_reg[ch] && clk_src[ch];
      cnt_wr[ch]  = wr_hit(bus, 4'(ch), IDX_CNT);
      for (int r = 0; r < NGR; r++) begin
        // C and D become plain buffers when their pair is buffered
        unit_on[ch][r] = !(r >= 2 && BUF_CH_MASK[ch] &&
                           ctrl_reg[ch][CTRL_BUF_LSB + r - 2]);
        cmp_hit[ch][r] = unit_on[ch][r] && !io_reg[ch][r*IO_W + IO_CAP_BIT] &&
                         tick[ch] && (cnt_reg[ch] == gr_reg[ch][r]);
        drive_on[ch][r] = unit_on[ch][r] && !io_reg[ch][r*IO_W + IO_CAP_BIT] &&
                          (io_reg[ch][r*IO_W +: 2] != OUT_NONE);
      end
    end
    for (int ch = 0; ch < NCH; ch++) begin
      for (int r = 0; r < NGR; r++) begin
        // Alternate sources; an undivided source clock gives no capture
        cap_hit[ch][r] = unit_on[ch][r] && start_reg[ch] &&
                         io_reg[ch][r*IO_W + IO_CAP_BIT] &&
                         edge_hit(io_reg[ch][r*IO_W +: 2], pin_s3_reg[ch][r],
                                  pin_s2_reg[ch][r],
                                  (ch == 0) ? (clk_src[1] && (mcct_cks_t'(
                                    ctrl_reg[1][CTRL_CKS_LSB +: 3]) != CK_DIV1))
                                  : (ch == 1) ? cmp_hit[0][0] : 1'b0);
      end
      case (mcct_clr_t'(ctrl_reg[ch][CTRL_CLR_LSB +: 3]))
        CLR_A:   own_clr[ch] = cmp_hit[ch][0] || cap_hit[ch][0];
        CLR_B:   own_clr[ch] = cmp_hit[ch][1] || cap_hit[ch][1];
        CLR_C:   own_clr[ch] = cmp_hit[ch][2] || cap_hit[ch][2];
        CLR_D:   own_clr[ch] = cmp_hit[ch][3] || cap_hit[ch][3];
        default: own_clr[ch] = 1'b0;
      endcase
    end
    sync_clr_any = |(own_clr & sync_reg);
    for (int ch = 0; ch < NCH; ch++) begin
      clr[ch] = own_clr[ch] ||
                (sync_reg[ch] && sync_clr_any && start_reg[ch] &&
                 (mcct_clr_t'(ctrl_reg[ch][CTRL_CLR_LSB +: 3]) == CLR_SYNC));
      ovf[ch] = tick[ch] && !clr[ch] && (cnt_reg[ch] == CNT_MAX);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters: preset, clear, count
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int ch = 0; ch < NCH; ch++) begin
        cnt_reg[ch] <= CNT_ZERO;
      end
    end else begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (cnt_wr[ch] || (sync_reg[ch] && |(cnt_wr & sync_reg))) begin
          cnt_reg[ch] <= bus.wdata;
        end else if (clr[ch]) begin
          cnt_reg[ch] <= CNT_ZERO;
        end else if (tick[ch]) begin
          cnt_reg[ch] <= cnt_reg[ch] + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // General registers: software write, capture, buffer transfers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int ch = 0; ch < NCH; ch++) begin
        for (int r = 0; r < NGR; r++) begin
          gr_reg[ch][r] <= CNT_MAX;
        end
      end
    end else begin
      for (int ch = 0; ch < NCH; ch++) begin
        for (int r = 0; r < NGR; r++) begin
          if (wr_hit(bus, 4'(ch), IDX_GRA + 4'(r))) begin
            gr_reg[ch][r] <= bus.wdata;
          end
        end
        for (int p = 0; p < 2; p++) begin
          if (!unit_on[ch][p+2]) begin
            if (cap_hit[ch][p]) begin
              gr_reg[ch][p+2] <= gr_reg[ch][p];
            end else if (cmp_hit[ch][p]) begin
              gr_reg[ch][p] <= gr_reg[ch][p+2];
            end
          end
        end
        for (int r = 0; r < NGR; r++) begin
          if (cap_hit[ch][r]) begin
            gr_reg[ch][r] <= cnt_reg[ch];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: hardware set wins over a write-one clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int ch = 0; ch < NCH; ch++) begin
        flag_reg[ch] <= '0;
      end
    end else begin
      for (int ch = 0; ch < NCH; ch++) begin
        flag_reg[ch] <= (flag_reg[ch] &
                         ~(wr_hit(bus, 4'(ch), IDX_FLAG) ? bus.wdata[4:0] : 5'h00)) |
                        {ovf[ch], cmp_hit[ch] | cap_hit[ch]};
      end
    end
  end

  // Interrupt requests per channel
  always_comb begin
    for (int ch = 0; ch < NCH; ch++) begin
      irq_req[ch] = |(flag_reg[ch] & ier_reg[ch]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int ch = 0; ch < NCH; ch++) begin
        ctrl_reg[ch] <= CTRL_RST;
        io_reg[ch]   <= IO_RST;
        ier_reg[ch]  <= '0;
      end
      start_reg <= '0;
      sync_reg  <= '0;
    end else begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (wr_hit(bus, 4'(ch), IDX_CTRL)) ctrl_reg[ch] <= bus.wdata[7:0];
        if (wr_hit(bus, 4'(ch), IDX_IOCTL)) io_reg[ch] <= bus.wdata;
        if (wr_hit(bus, 4'(ch), IDX_IER)) ier_reg[ch] <= bus.wdata[4:0];
      end
      if (wr_hit(bus, GLB_CH, IDX_START)) start_reg <= bus.wdata[NCH-1:0];
      if (wr_hit(bus, GLB_CH, IDX_SYNC)) sync_reg <= bus.wdata[NCH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare outputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      out_reg <= '0;
    end else begin
      for (int ch = 0; ch < NCH; ch++) begin
        for (int r = 0; r < NGR; r++) begin
          if (cmp_hit[ch][r]) begin
            case (mcct_out_t'(io_reg[ch][r*IO_W +: 2]))
              OUT_LOW:    out_reg[ch][r] <= 1'b0;
              OUT_HIGH:   out_reg[ch][r] <= 1'b1;
              OUT_TOGGLE: out_reg[ch][r] <= !out_reg[ch][r];
              default:    out_reg[ch][r] <= out_reg[ch][r];
            endcase
          end
        end
      end
    end
  end

  assign pin_out  = out_reg;
  assign pin_oe_n = ~drive_on;

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data in the cycle after the strobe, unmapped reads zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_reg <= RD_ZERO;
    end else if (bus.rd) begin
      rd_reg <= RD_ZERO;
      for (int ch = 0; ch < NCH; ch++) begin
        if (bus.addr[7:4] == 4'(ch)) begin
          case (bus.addr[3:0])
            IDX_CTRL:  rd_reg <= {8'h00, ctrl_reg[ch]};
            IDX_IOCTL: rd_reg <= io_reg[ch];
            IDX_IER:   rd_reg <= {11'h000, ier_reg[ch]};
            IDX_FLAG:  rd_reg <= {11'h000, flag_reg[ch]};
            IDX_CNT:   rd_reg <= cnt_reg[ch];
            4'h5:      rd_reg <= gr_reg[ch][0];
            4'h6:      rd_reg <= gr_reg[ch][1];
            4'h7:      rd_reg <= gr_reg[ch][2];
            4'h8:      rd_reg <= gr_reg[ch][3];
            default:   rd_reg <= RD_ZERO;
          endcase
        end
      end
      if (bus.addr[7:4] == GLB_CH && bus.addr[3:0] == IDX_START) begin
        rd_reg <= {11'h000, start_reg};
      end
      if (bus.addr[7:4] == GLB_CH && bus.addr[3:0] == IDX_SYNC) begin
        rd_reg <= {11'h000, sync_reg};
      end
    end else begin
      rd_reg <= RD_ZERO;
    end
  end

  assign rd_data = rd_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_cnt_read;
    bus.rd && bus.addr == {4'h0, IDX_CNT};
  endsequence

  a_cnt_readback: assert property (s_cnt_read ##1 1'b1 |-> rd_data == $past(cnt_reg[0]))
    else $error("counter read data wrong");

  for (genvar g = 0; g < NCH; g++) begin : g_chk
    a_count_step: assert property (tick[g] && !clr[g] && !(|(cnt_wr)) |=>
                                   cnt_reg[g] == $past(cnt_reg[g]) + 16'h0001)
      else $error("counter did not step");
    a_stop_hold: assert property (!start_reg[g] && !(|cnt_wr) |=> $stable(cnt_reg[g]))
      else $error("stopped counter moved");
    a_ovf_wrap: assert property (ovf[g] && !(|cnt_wr) |=>
                                 cnt_reg[g] == CNT_ZERO && flag_reg[g][FLAG_OVF_BIT])
      else $error("overflow did not wrap and flag");
    a_match_clear: assert property (own_clr[g] && cmp_hit[g][0] && !(|cnt_wr) |=>
                                    cnt_reg[g] == CNT_ZERO && flag_reg[g][0])
      else $error("match did not clear counter");
    a_irq_level: assert property (cmp_hit[g][0] && ier_reg[g][0] && !bus.wr |=> irq_req[g])
      else $error("interrupt missing");
    a_cap_load: assert property (cap_hit[g][2] |=> gr_reg[g][2] == $past(cnt_reg[g]))
      else $error("capture did not load count");
    a_pin_high: assert property (cmp_hit[g][0] &&
                                 io_reg[g][1:0] == OUT_HIGH && !io_reg[g][IO_CAP_BIT]
                                 |=> pin_out[g][0])
      else $error("compare did not drive high");
    a_sync_load: assert property (|(cnt_wr & sync_reg) && sync_reg[g] |=>
                                  cnt_reg[g] == $past(bus.wdata))
      else $error("synchronous preset missed");
    a_buf_capture: assert property (cap_hit[g][0] && !unit_on[g][2] |=>
                                    gr_reg[g][2] == $past(gr_reg[g][0]))
      else $error("buffered capture did not shift");
    a_buf_compare: assert property (cmp_hit[g][0] && !unit_on[g][2] |=>
                                    gr_reg[g][0] == $past(gr_reg[g][2]))
      else $error("buffered compare did not reload");
  end

endmodule
